// ---- src/timer_counter.v ----
/*
 * 16-bit timer/counter with prescaler, overflow flag, compare-trigger reset,
 * wide buffered access and secondary clock status, on an avalon-mm slave.
 * assumes all inputs synchronous to CLK_I; the external count input is sampled.
 */
// Operation
// - select field 01 enters secondary run, everything clocked by timer oscillator.
// - idle-on-sleep clear plus sleep on secondary clock enters secondary idle.
// - secondary clock active bit reads one only while oscillator clocks system.
// - after oscillator failure under monitor, active bit shows the real source.
// - 16-bit count increments and wraps from ffff to 0000.
// - each wrap sets overflow flag; request raised only when enable set.
// - compare unit one or two on this timer in mode 1011 clears count.
// - trigger from unit two also starts a conversion when converter enabled.
// - trigger reset works in timer and synchronous modes, not asynchronous.
// - software count write in the trigger cycle wins over the trigger.
// - trigger reset never sets the overflow flag.
// - asynchronous mode needs the input seen low after update before counting.
// - source select zero counts instruction cycles, one counts input rising edges.
// - prescale field divides count clock by 1, 2, 4 or 8.
// - wide mode low read latches high into buffer; low write loads high.
// - low byte write clears prescaler; high byte write does not.
`include "timer_counter_regs.vh"

module timer_counter (
	// clock and reset
	input wire CLK_I,
	input wire RESET_N_I,
	// avalon-mm slave
	input wire [5:0] AVS_ADDRESS_I,
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire [31:0] AVS_WRITEDATA_I,
	input wire [3:0] AVS_BYTEENABLE_I,
	output reg [31:0] AVS_READDATA_O,
	output reg AVS_WAITREQUEST_O,
	// count sources
	input wire INSTR_TICK_I,
	input wire EXT_COUNT_I,
	// compare units and converter
	input wire CMP1_TRIGGER_I,
	input wire CMP2_TRIGGER_I,
	input wire CONVERTER_ENABLE_I,
	output reg CONVERSION_START_O,
	// clock switch and overflow request
	input wire SLEEP_CMD_I,
	input wire OSC_FAIL_I,
	output reg SECONDARY_RUN_O,
	output reg SECONDARY_IDLE_O,
	output reg OVERFLOW_IRQ_O
);

	localparam ST_PRIMARY = 3'b001;
	localparam ST_SEC_RUN = 3'b010;
	localparam ST_SEC_IDLE = 3'b100;

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [15:0] count;
	reg [7:0] high_buffer;
	reg [2:0] prescale;
	reg [7:0] timer_control;
	reg [7:0] flags;
	reg [7:0] enables;
	reg [7:0] priorities;
	reg [7:0] oscillator_control;
	reg [7:0] compare_cfg;
	reg [2:0] power_state;
	reg ext_prev;
	reg armed;
	reg pending;

	reg [15:0] next_count;
	reg [7:0] next_high_buffer;
	reg [2:0] next_prescale;
	reg next_flag_ovf;
	reg wrap;
	reg [2:0] next_power_state;
	reg next_armed;
	reg tick;
	reg edge_tick;
	reg trigger;
	reg [31:0] next_readdata;

	wire first_cycle = (AVS_READ_I | AVS_WRITE_I) & ~pending;
	wire [3:0] index = AVS_ADDRESS_I[5:2];
	wire wr_en = AVS_WRITE_I & pending & AVS_BYTEENABLE_I[0];
	// read data is captured on the first edge so it already stands while waitrequest is low
	wire rd_en = AVS_READ_I & ~pending;
	wire [7:0] wbyte = AVS_WRITEDATA_I[7:0];
	wire wide = timer_control[`CTL_WIDE];
	wire async_mode = timer_control[`CTL_SRC] & timer_control[`CTL_NOSYNC];
	wire wr_low = wr_en & (index == `REG_COUNT_LOW);
	wire wr_high = wr_en & (index == `REG_COUNT_HIGH);
	// a failed oscillator never reads as the active source
	wire osc_active = (power_state != ST_PRIMARY) & ~OSC_FAIL_I;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function ps_done;
		input [2:0] cnt;
		input [1:0] sel;
		begin
			case (sel)
				2'b00: ps_done = 1'b1;
				2'b01: ps_done = cnt[0];
				2'b10: ps_done = &cnt[1:0];
				default: ps_done = &cnt;
			endcase
		end
	endfunction

	function unit_triggers;
		input fired;
		input [3:0] mode;
		input uses_timer;
		begin
			unit_triggers = fired & uses_timer & (mode == `CMP_MODE_TRIGGER);
		end
	endfunction

	// ----------------------------------------
	// counting
	// ----------------------------------------
	always @* begin
		next_armed = armed;
		edge_tick = 1'b0;
		if (~EXT_COUNT_I) begin
			next_armed = 1'b1;
		end
		// rising edge of the synchronous count level
		if (EXT_COUNT_I & ~ext_prev & armed) begin
			edge_tick = 1'b1;
		end
		// asynchronous mode stays disarmed until the input is seen low
		if (wr_low | wr_high) begin
			next_armed = ~EXT_COUNT_I & ~async_mode;
		end
		tick = timer_control[`CTL_SRC] ? edge_tick : INSTR_TICK_I;
		trigger = (unit_triggers(CMP1_TRIGGER_I, compare_cfg[3:0], compare_cfg[4]) |
			unit_triggers(CMP2_TRIGGER_I, compare_cfg[3:0], compare_cfg[5])) & ~async_mode;
		next_count = count;
		next_prescale = prescale;
		next_high_buffer = high_buffer;
		wrap = 1'b0;
		if (timer_control[`CTL_ON] & tick) begin
			if (ps_done(prescale, timer_control[`CTL_PS_HI:`CTL_PS_LO])) begin
				next_prescale = 3'b000;
				next_count = count + 16'h0001;
				if (count == `COUNT_MAX) begin
					wrap = 1'b1;
				end
			end else begin
				next_prescale = prescale + 3'b001;
			end
		end
		if (trigger) begin
			next_count = `RESET_COUNT;
		end
		if (rd_en & (index == `REG_COUNT_LOW) & wide) begin
			next_high_buffer = count[15:8];
		end
		// a count write in the trigger cycle overrides the cleared count
		if (wr_high) begin
			if (wide) begin
				next_high_buffer = wbyte;
			end else begin
				next_count = {wbyte, next_count[7:0]};
			end
		end
		if (wr_low) begin
			next_prescale = 3'b000;
			next_count = {wide ? high_buffer : next_count[15:8], wbyte};
		end
	end

	// ----------------------------------------
	// overflow flag
	// ----------------------------------------
	always @* begin
		next_flag_ovf = flags[`FLAG_OVF] | wrap;
		// a clear written in the wrap cycle loses
		if (wr_en & (index == `REG_FLAGS)) begin
			next_flag_ovf = wbyte[`FLAG_OVF] | wrap;
		end
	end

	// ----------------------------------------
	// clock switch
	// ----------------------------------------
	always @* begin
		next_power_state = power_state;
		case (power_state)
			ST_PRIMARY: begin
				if (oscillator_control[`OSC_SEL_HI:`OSC_SEL_LO] == `SEL_SECONDARY) begin
					next_power_state = ST_SEC_RUN;
				end
			end
			ST_SEC_RUN: begin
				if (oscillator_control[`OSC_SEL_HI:`OSC_SEL_LO] != `SEL_SECONDARY) begin
					next_power_state = ST_PRIMARY;
				end else if (SLEEP_CMD_I & ~oscillator_control[`OSC_IDLE]) begin
					next_power_state = ST_SEC_IDLE;
				end
			end
			ST_SEC_IDLE: begin
				if (oscillator_control[`OSC_SEL_HI:`OSC_SEL_LO] != `SEL_SECONDARY) begin
					next_power_state = ST_PRIMARY;
				end
			end
			default: next_power_state = ST_PRIMARY;
		endcase
		// monitor falls back to the primary clock
		if (OSC_FAIL_I & oscillator_control[`OSC_FAILSAFE]) begin
			next_power_state = ST_PRIMARY;
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always @* begin
		next_readdata = 32'h0000_0000;
		case (index)
			`REG_COUNT_LOW: next_readdata[7:0] = count[7:0];
			`REG_COUNT_HIGH: next_readdata[7:0] = wide ? high_buffer : count[15:8];
			`REG_TIMER_CONTROL: next_readdata[7:0] = {timer_control[7], osc_active, timer_control[5:0]};
			`REG_FLAGS: next_readdata[7:0] = flags;
			`REG_ENABLES: next_readdata[7:0] = enables;
			`REG_PRIORITIES: next_readdata[7:0] = priorities;
			`REG_OSC_CONTROL: next_readdata[7:0] = oscillator_control;
			`REG_COMPARE_CFG: next_readdata[7:0] = compare_cfg;
			`REG_POWER_STATUS: next_readdata[7:0] = {5'b0_0000, power_state};
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always @(posedge CLK_I or negedge RESET_N_I) begin
		if (~RESET_N_I) begin
			count <= `RESET_COUNT;
			high_buffer <= `RESET_BYTE;
			prescale <= 3'b000;
			timer_control <= `RESET_BYTE;
			flags <= `RESET_BYTE;
			enables <= `RESET_BYTE;
			priorities <= `RESET_BYTE;
			oscillator_control <= `RESET_BYTE;
			compare_cfg <= `RESET_BYTE;
			power_state <= ST_PRIMARY;
			ext_prev <= 1'b0;
			armed <= 1'b0;
			pending <= 1'b0;
			AVS_READDATA_O <= 32'h0000_0000;
			AVS_WAITREQUEST_O <= 1'b1;
			CONVERSION_START_O <= 1'b0;
			SECONDARY_RUN_O <= 1'b0;
			SECONDARY_IDLE_O <= 1'b0;
			OVERFLOW_IRQ_O <= 1'b0;
		end else begin
			count <= next_count;
			high_buffer <= next_high_buffer;
			prescale <= next_prescale;
			flags <= {flags[7:1], next_flag_ovf};
			power_state <= next_power_state;
			ext_prev <= EXT_COUNT_I;
			armed <= next_armed;
			// one wait state: waitrequest drops for the second edge of each request
			pending <= first_cycle;
			AVS_WAITREQUEST_O <= ~first_cycle;
			if (rd_en) begin
				AVS_READDATA_O <= next_readdata;
			end
			if (wr_en) begin
				case (index)
					`REG_TIMER_CONTROL: timer_control <= {wbyte[7], 1'b0, wbyte[5:0]};
					`REG_FLAGS: flags[7:1] <= wbyte[7:1];
					`REG_ENABLES: enables <= wbyte;
					`REG_PRIORITIES: priorities <= wbyte;
					`REG_OSC_CONTROL: oscillator_control <= wbyte;
					`REG_COMPARE_CFG: compare_cfg <= wbyte;
					default: ;
				endcase
			end
			CONVERSION_START_O <= unit_triggers(CMP2_TRIGGER_I, compare_cfg[3:0], compare_cfg[5]) &
				~async_mode & CONVERTER_ENABLE_I;
			SECONDARY_RUN_O <= next_power_state == ST_SEC_RUN;
			SECONDARY_IDLE_O <= next_power_state == ST_SEC_IDLE;
			OVERFLOW_IRQ_O <= next_flag_ovf & enables[`FLAG_OVF];
		end
	end

endmodule

// ---- src/timer_counter_regs.vh ----
/*
 * register offsets, field positions and reset values of the
 * 16-bit timer/counter. assumes inclusion by the timer top module only.
 */
`ifndef TIMER_COUNTER_REGS_VH
`define TIMER_COUNTER_REGS_VH

// ----------------------------------------
// register word offsets (byte address = 4 * index)
// ----------------------------------------
`define REG_COUNT_LOW 4'h0
`define REG_COUNT_HIGH 4'h1
`define REG_TIMER_CONTROL 4'h2
`define REG_FLAGS 4'h3
`define REG_ENABLES 4'h4
`define REG_PRIORITIES 4'h5
`define REG_OSC_CONTROL 4'h6
`define REG_COMPARE_CFG 4'h7
`define REG_POWER_STATUS 4'h8
`define REG_POWER_CMD 4'h9

// ----------------------------------------
// timer control fields
// ----------------------------------------
`define CTL_ON 0
`define CTL_SRC 1
`define CTL_NOSYNC 2
`define CTL_OSCEN 3
`define CTL_PS_LO 4
`define CTL_PS_HI 5
`define CTL_ACTIVE 6
`define CTL_WIDE 7

// ----------------------------------------
// oscillator control and compare configuration fields
// ----------------------------------------
`define OSC_SEL_LO 0
`define OSC_SEL_HI 1
`define OSC_FAILSAFE 2
`define OSC_IDLE 7
`define SEL_SECONDARY 2'b01
`define CMP_MODE_TRIGGER 4'b1011
`define FLAG_OVF 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RESET_BYTE 8'h00
`define RESET_COUNT 16'h0000
`define COUNT_MAX 16'hffff

`endif

// ---- test/osc_model.sv ----
/*
 * model of the external count source at the timer's far side.
 * assumes a rising-edge system clock; output is synchronous to it.
 */
module osc_model #(parameter int HALF = 4) (
	// clock and enable
	input wire logic clk_i,
	input wire logic en_i,
	// count level
	output logic ext_o = 1'b0
);
	int n = 0;
	// stands low between bursts
	always @(posedge clk_i) begin
		if (!en_i) begin
			n <= 0;
			ext_o <= 1'b0;
		end else if (n == HALF - 1) begin
			n <= 0;
			ext_o <= ~ext_o;
		end else begin
			n <= n + 1;
		end
	end
endmodule

// ---- test/timer_counter_asserts.sv ----
/*
 * port-level checks of the timer/counter.
 * assumes binding to timer_counter; one clock domain.
 */
module timer_counter_asserts (
	input logic CLK_I,
	input logic RESET_N_I,
	input logic AVS_READ_I,
	input logic AVS_WRITE_I,
	input logic [31:0] AVS_READDATA_O,
	input logic AVS_WAITREQUEST_O,
	input logic CMP2_TRIGGER_I,
	input logic CONVERTER_ENABLE_I,
	input logic CONVERSION_START_O,
	input logic SLEEP_CMD_I,
	input logic SECONDARY_RUN_O,
	input logic SECONDARY_IDLE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	wait_one_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("waitrequest low longer than one cycle");
	idle_wait_a: assert property (!AVS_READ_I && !AVS_WRITE_I |=> AVS_WAITREQUEST_O)
		else $error("waitrequest low without request");
	read_answer_a: assert property (AVS_READ_I && !$past(AVS_READ_I) |=> !AVS_WAITREQUEST_O)
		else $error("read not answered next cycle");
	data_hold_a: assert property (!$past(AVS_READ_I) |-> $stable(AVS_READDATA_O))
		else $error("read data changed without read");
	upper_zero_a: assert property (AVS_READDATA_O[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	conv_cause_a: assert property (CONVERSION_START_O |-> $past(CMP2_TRIGGER_I && CONVERTER_ENABLE_I))
		else $error("conversion start without enabled trigger");
	state_excl_a: assert property (!(SECONDARY_RUN_O && SECONDARY_IDLE_O))
		else $error("run and idle together");
	idle_entry_a: assert property ($rose(SECONDARY_IDLE_O) |-> $past(SLEEP_CMD_I) || $past(SLEEP_CMD_I, 2))
		else $error("idle entered without sleep");
endmodule

bind timer_counter timer_counter_asserts chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .AVS_READ_I(AVS_READ_I),
	.AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.CMP2_TRIGGER_I(CMP2_TRIGGER_I), .CONVERTER_ENABLE_I(CONVERTER_ENABLE_I),
	.CONVERSION_START_O(CONVERSION_START_O), .SLEEP_CMD_I(SLEEP_CMD_I),
	.SECONDARY_RUN_O(SECONDARY_RUN_O), .SECONDARY_IDLE_O(SECONDARY_IDLE_O));

// ---- test/testbench.sv ----
/*
 * register-level tests of the timer/counter over avalon-mm.
 * assumes osc_model drives the external count input.
 */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, tk = 0, c1 = 0, c2 = 0, cen = 0, slp = 0, fl = 0, en = 0;
	logic [5:0] addr = 6'h00;
	logic [31:0] wd = 32'h0000_0000;
	wire [31:0] rdata;
	wire wq, ext, conv, srun, sidle, irq;
	int n_mismatch = 0, num_checks = 0;
	always #2 clk = ~clk;
	osc_model #(.HALF(4)) osc (.clk_i(clk), .en_i(en), .ext_o(ext));
	timer_counter dut (.CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'h1), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(wq), .INSTR_TICK_I(tk), .EXT_COUNT_I(ext), .CMP1_TRIGGER_I(c1),
		.CMP2_TRIGGER_I(c2), .CONVERTER_ENABLE_I(cen), .CONVERSION_START_O(conv), .SLEEP_CMD_I(slp),
		.OSC_FAIL_I(fl), .SECONDARY_RUN_O(srun), .SECONDARY_IDLE_O(sidle), .OVERFLOW_IRQ_O(irq));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wrr(input logic [3:0] i, input logic [7:0] d);
		@(posedge clk);
		addr <= {i, 2'b00};
		wd <= {24'h00_0000, d};
		wr <= 1;
		@(posedge clk iff wq === 1'b0);
		wr <= 0;
	endtask
	task rc(input logic [3:0] i, input logic [31:0] e);
		@(posedge clk);
		addr <= {i, 2'b00};
		rd <= 1;
		@(posedge clk iff wq === 1'b0);
		rd <= 0;
		chk(rdata, e);
	endtask
	task tick(input int n);
		repeat (n) begin
			@(posedge clk);
			tk <= 1;
			@(posedge clk);
			tk <= 0;
		end
	endtask
	task trig2(input logic e);
		@(posedge clk);
		cen <= e;
		c2 <= 1;
		@(posedge clk);
		c2 <= 0;
		#1 chk(conv, e);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		// ----------------
		// reset values, unmapped place, prescale, overflow, triggers, edge count, wide, clock switch
		// ----------------
		for (int i = 0; i < 10; i++) rc(i, i == 8);
		wrr(9, 8'hff);
		rc(9, 0);
		for (int p = 0; p < 4; p++) begin
			wrr(2, p << 4);
			wrr(1, 0);
			wrr(0, 0);
			wrr(2, (p << 4) | 1);
			tick(8);
			rc(0, 8 >> p);
		end
		wrr(2, 0);
		wrr(1, 8'hff);
		wrr(0, 8'hfe);
		wrr(4, 1);
		wrr(2, 1);
		tick(2);
		rc(0, 0);
		rc(1, 0);
		rc(3, 1);
		chk(irq, 1);
		wrr(3, 0);
		rc(3, 0);
		chk(irq, 0);
		tick(3);
		wrr(2, 0);
		tick(5);
		rc(0, 3);
		wrr(7, 8'h1b);
		wrr(2, 1);
		tick(2);
		@(posedge clk);
		c1 <= 1;
		@(posedge clk);
		c1 <= 0;
		rc(0, 0);
		rc(3, 0);
		wrr(7, 8'h2b);
		trig2(1);
		trig2(0);
		@(posedge clk);
		c2 <= 1;
		wrr(0, 8'h42);
		c2 <= 0;
		rc(0, 8'h42);
		wrr(2, 8'h03);
		wrr(1, 0);
		wrr(0, 0);
		@(posedge clk);
		en <= 1;
		repeat (80) @(posedge clk);
		en <= 0;
		rc(0, 80 / 8);
		wrr(2, 8'h80);
		wrr(1, 8'h12);
		wrr(0, 8'h34);
		rc(0, 8'h34);
		rc(1, 8'h12);
		wrr(6, 8'h01);
		repeat (2) @(posedge clk);
		chk(srun, 1);
		rc(2, 8'hc0);
		@(posedge clk);
		slp <= 1;
		@(posedge clk);
		slp <= 0;
		repeat (2) @(posedge clk);
		#1 chk(sidle, 1);
		wrr(6, 8'h05);
		fl <= 1;
		repeat (3) @(posedge clk);
		rc(2, 8'h80);
		// ----------------
		// asynchronous counting, real-time use
		// ----------------
		wrr(7, 8'h1b);
		wrr(2, 8'h0e);
		wrr(4, 1);
		wrr(1, 8'hff);
		wrr(0, 8'hf8);
		wrr(2, 8'h0f);
		@(posedge clk);
		c1 <= 1;
		@(posedge clk);
		c1 <= 0;
		rc(0, 8'hf8);
		@(posedge clk);
		en <= 1;
		repeat (64) @(posedge clk);
		en <= 0;
		rc(0, 0);
		rc(3, 1);
		chk(irq, 1);
		wrr(1, 8'h80);
		rc(1, 8'h80);
		rc(0, 0);
		give_verdict();
	end
endmodule
